// ==== psa_adv_regs.vh ====
`ifndef PSA_ADV_REGS_VH
`define PSA_ADV_REGS_VH

// register indices on the serial register port
`define PSA_ADDR_W 6
`define PSA_ADDR_CH1_TUNE 6'h2e
`define PSA_ADDR_CH2_TUNE 6'h2f

// reset values, reserved bits excluded
`define PSA_CH1_TUNE_RST 16'h4000
`define PSA_CH2_TUNE_RST 16'h0000
// writable masks: reserved positions stay zero
`define PSA_CH1_TUNE_MASK 16'hfbfd
`define PSA_CH2_TUNE_MASK 16'h9e7f

// channel-one tuning fields
`define PSA_C1_KEEP_ON 15
`define PSA_C1_LEVEL_HI 14
`define PSA_C1_LEVEL_LO 11
`define PSA_C1_TRACK_FAST 9
`define PSA_C1_BLANK_HI 8
`define PSA_C1_BLANK_LO 7
`define PSA_C1_FILT_HI 6
`define PSA_C1_FILT_LO 3
`define PSA_C1_HOLD_DIS 2
`define PSA_C1_STATIC 0

// channel-two tuning fields: decoder, loop reset delay and sync delay
`define PSA_C2_LOOP_DELAY 15
`define PSA_C2_LONG_BIT2 12
`define PSA_C2_PERIOD_OFF2 11
`define PSA_C2_DUTY_OFF2 10
`define PSA_C2_CNT_CLR2 9
`define PSA_C2_LONG_BIT1 6
`define PSA_C2_PERIOD_OFF1 5
`define PSA_C2_DUTY_OFF1 4
`define PSA_C2_CNT_CLR1 3
`define PSA_C2_SYNC_HI 2
`define PSA_C2_SYNC_LO 0

// blanking selector codes
`define PSA_BLANK_5MS 2'b01
`define PSA_BLANK_10MS 2'b10

// static threshold above base, in units of 1/32 mA
`define PSA_THR_BASE_Q5 9'd176
`define PSA_THR_STEP_Q5 9'd19
`define PSA_THR_MAX_Q5 9'd460

// deglitch: filter base in 16 MHz periods, conversion 62.5 ns / 40 ns = 25/16 rounded up
`define PSA_FILT_BASE_FAST 6'd16
`define PSA_FILT_BASE_SLOW 6'd24
`define PSA_FILT_MUL 11'd25
`define PSA_FILT_ROUND 11'd15

// times in ns and the clock period
`define PSA_CLK_NS 40
`define PSA_BLANK_SHORT_NS 128000
`define PSA_BLANK_5MS_NS 5000000
`define PSA_BLANK_10MS_NS 10000000
`define PSA_LOOP_DELAY_NS 20000000
`define PSA_SYNC_STEP_NS 2000

`endif

// ==== psa_timer.v ====
`timescale 1ns/1ps
module psa_timer #(
    parameter W = 19
) (
    input wire clock_i,
    input wire arst_n_i,
    input wire load_i,
    input wire [W-1:0] value_i,
    output wire busy_o,
    output wire done_o
);

// runs value_i+1 cycles after load; a new load restarts the wait
reg [W-1:0] cnt_reg;
reg active_reg;

assign busy_o = active_reg;
assign done_o = active_reg && (cnt_reg == {W{1'b0}}) && !load_i;

always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        cnt_reg <= {W{1'b0}};
        active_reg <= 1'b0;
    end else if (load_i) begin
        cnt_reg <= value_i;
        active_reg <= 1'b1;
    end else if (active_reg) begin
        if (cnt_reg == {W{1'b0}}) begin
            active_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
    end
end

endmodule // psa_timer

// ==== psa_deglitch.v ====
`timescale 1ns/1ps
module psa_deglitch (
    input wire clock_i,
    input wire arst_n_i,
    input wire [6:0] len_i,
    input wire din_i,
    output wire dout_o
);

// output follows the input only after it has differed for len_i cycles
reg [6:0] cnt_reg;
reg out_reg;

assign dout_o = out_reg;

always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        cnt_reg <= 7'h00;
        out_reg <= 1'b0;
    end else if (din_i == out_reg) begin
        cnt_reg <= 7'h00;
    end else if (cnt_reg + 7'h01 >= len_i) begin
        out_reg <= din_i;
        cnt_reg <= 7'h00;
    end else begin
        cnt_reg <= cnt_reg + 7'h01;
    end
end

endmodule // psa_deglitch

// ==== psa_adv_settings.v ====
`timescale 1ns/1ps
`include "psa_adv_regs.vh"
module psa_adv_settings #(
    parameter BLANK_5MS_CYC = `PSA_BLANK_5MS_NS / `PSA_CLK_NS,
    parameter BLANK_10MS_CYC = `PSA_BLANK_10MS_NS / `PSA_CLK_NS,
    parameter LOOP_DELAY_CYC = `PSA_LOOP_DELAY_NS / `PSA_CLK_NS
) (
    input wire clock_i,
    input wire arst_n_i,
    // register port
    input wire [5:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [15:0] reg_wdata_i,
    output wire [15:0] reg_rdata_o,
    // channel-one line conditioning
    input wire rate_fast_i,
    input wire ch1_data_i,
    input wire ch1_ground_short_i,
    input wire ch1_sensor_start_i,
    input wire ch1_start_bits_seen_i,
    output wire ch1_data_o,
    output wire ch1_channel_off_o,
    output wire ch1_blanking_o,
    output wire ch1_base_hold_o,
    output wire ch1_threshold_static_o,
    output wire [8:0] ch1_threshold_delta_o,
    output wire ch1_tracking_fast_o,
    // decoder conditioning, bit 0 channel one, bit 1 channel two
    input wire [1:0] long_bit_i,
    input wire [1:0] start_duty_low_i,
    input wire [1:0] start_bit_err_i,
    output wire [1:0] long_bit_error_o,
    output wire [1:0] start_period_meas_en_o,
    output wire [1:0] start_duty_error_o,
    output wire [1:0] bit_counter_clear_o,
    // frequency-locked loop
    input wire loop_error_i,
    output wire loop_reset_o,
    // sync pulse generation
    input wire ch1_sync_auto_i,
    input wire ch2_sync_auto_i,
    input wire ch2_sync_req_i,
    output wire ch2_sync_pulse_o
);

// counts are worked out as integers and cut to the counter width on purpose
localparam integer BLANK_SHORT_CYC = `PSA_BLANK_SHORT_NS / `PSA_CLK_NS;
localparam integer SYNC_STEP_INT = `PSA_SYNC_STEP_NS / `PSA_CLK_NS;
localparam [18:0] BLANK_SHORT_M1 = BLANK_SHORT_CYC[18:0] - 19'd1;
localparam [18:0] BLANK_5MS_M1 = BLANK_5MS_CYC[18:0] - 19'd1;
localparam [18:0] BLANK_10MS_M1 = BLANK_10MS_CYC[18:0] - 19'd1;
localparam [18:0] LOOP_DELAY_M1 = LOOP_DELAY_CYC[18:0] - 19'd1;
// the 2 us step is a whole number of 40 ns cycles, so the sync delay is exact
localparam [8:0] SYNC_STEP_CYC = SYNC_STEP_INT[8:0];

////////////////////////////////////////////////////////////////////////////////
// registers

reg [15:0] ch1_tune_reg;
reg [15:0] ch2_tune_reg;
reg [15:0] rdata_reg;
reg [15:0] rdata_next;

always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        ch1_tune_reg <= `PSA_CH1_TUNE_RST;
        ch2_tune_reg <= `PSA_CH2_TUNE_RST;
    end else if (reg_wr_i) begin
        if (reg_addr_i == `PSA_ADDR_CH1_TUNE) begin
            ch1_tune_reg <= reg_wdata_i & `PSA_CH1_TUNE_MASK;
        end
        if (reg_addr_i == `PSA_ADDR_CH2_TUNE) begin
            ch2_tune_reg <= reg_wdata_i & `PSA_CH2_TUNE_MASK;
        end
    end
end

// read data is registered: it shows the addressed register one cycle later
always @* begin
    case (reg_addr_i)
        `PSA_ADDR_CH1_TUNE: rdata_next = ch1_tune_reg;
        `PSA_ADDR_CH2_TUNE: rdata_next = ch2_tune_reg;
        default: rdata_next = 16'h0000;
    endcase
end

always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        rdata_reg <= 16'h0000;
    end else begin
        rdata_reg <= rdata_next;
    end
end

assign reg_rdata_o = rdata_reg;

////////////////////////////////////////////////////////////////////////////////
// field decode

wire keep_on = ch1_tune_reg[`PSA_C1_KEEP_ON];
wire [3:0] static_level = ch1_tune_reg[`PSA_C1_LEVEL_HI:`PSA_C1_LEVEL_LO];
wire [1:0] blank_sel = ch1_tune_reg[`PSA_C1_BLANK_HI:`PSA_C1_BLANK_LO];
wire [3:0] deglitch_adjust = ch1_tune_reg[`PSA_C1_FILT_HI:`PSA_C1_FILT_LO];
wire [1:0] long_bit_en = {ch2_tune_reg[`PSA_C2_LONG_BIT2], ch2_tune_reg[`PSA_C2_LONG_BIT1]};
wire [1:0] period_off = {ch2_tune_reg[`PSA_C2_PERIOD_OFF2], ch2_tune_reg[`PSA_C2_PERIOD_OFF1]};
wire [1:0] duty_off = {ch2_tune_reg[`PSA_C2_DUTY_OFF2], ch2_tune_reg[`PSA_C2_DUTY_OFF1]};
wire [1:0] cnt_clr_en = {ch2_tune_reg[`PSA_C2_CNT_CLR2], ch2_tune_reg[`PSA_C2_CNT_CLR1]};
wire [2:0] pulse_delay = ch2_tune_reg[`PSA_C2_SYNC_HI:`PSA_C2_SYNC_LO];

////////////////////////////////////////////////////////////////////////////////
// deglitch filter and ground short

// filter length in 16 MHz periods, converted up to whole 40 ns cycles
wire [5:0] filt_base = rate_fast_i ? `PSA_FILT_BASE_FAST : `PSA_FILT_BASE_SLOW;
wire [5:0] filt_sum = filt_base + {2'b00, deglitch_adjust};
wire [10:0] filt_num = {5'd0, filt_sum} * `PSA_FILT_MUL + `PSA_FILT_ROUND;
wire [6:0] filt_cyc = filt_num[10:4];
wire short_filtered;

psa_deglitch u_data_filt (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .len_i(filt_cyc),
    .din_i(ch1_data_i),
    .dout_o(ch1_data_o)
);

// the short is judged after the same filter time as the data line
psa_deglitch u_short_filt (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .len_i(filt_cyc),
    .din_i(ch1_ground_short_i),
    .dout_o(short_filtered)
);

reg channel_off_reg;

always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        channel_off_reg <= 1'b0;
    end else begin
        channel_off_reg <= short_filtered && !keep_on;
    end
end

assign ch1_channel_off_o = channel_off_reg;

////////////////////////////////////////////////////////////////////////////////
// threshold, tracking, base hold

// 5.5 mA + 9.5/16 mA per count, in 1/32 mA; code 15 would exceed 14.4 mA
wire [8:0] thr_raw = `PSA_THR_BASE_Q5 + `PSA_THR_STEP_Q5 * {5'd0, static_level};
reg [8:0] thr_reg;
reg static_reg;
reg track_reg;
reg hold_reg;

always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        thr_reg <= `PSA_THR_BASE_Q5;
        static_reg <= 1'b0;
        track_reg <= 1'b0;
        hold_reg <= 1'b0;
    end else begin
        thr_reg <= (thr_raw > `PSA_THR_MAX_Q5) ? `PSA_THR_MAX_Q5 : thr_raw;
        static_reg <= ch1_tune_reg[`PSA_C1_STATIC];
        track_reg <= ch1_tune_reg[`PSA_C1_TRACK_FAST];
        hold_reg <= ch1_start_bits_seen_i && !ch1_tune_reg[`PSA_C1_HOLD_DIS];
    end
end

assign ch1_threshold_delta_o = thr_reg;
assign ch1_threshold_static_o = static_reg;
assign ch1_tracking_fast_o = track_reg;
assign ch1_base_hold_o = hold_reg;

////////////////////////////////////////////////////////////////////////////////
// start-up blanking

reg [18:0] blank_len;

always @* begin
    case (blank_sel)
        `PSA_BLANK_5MS: blank_len = BLANK_5MS_M1;
        `PSA_BLANK_10MS: blank_len = BLANK_10MS_M1;
        default: blank_len = BLANK_SHORT_M1;
    endcase
end

// a start pulse while blanking reloads the count from the selector as it stands
psa_timer #(.W(19)) u_blank (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .load_i(ch1_sensor_start_i),
    .value_i(blank_len),
    .busy_o(ch1_blanking_o),
    .done_o()
);

////////////////////////////////////////////////////////////////////////////////
// decoder conditioning

reg [1:0] long_err_reg;
reg [1:0] duty_err_reg;
reg [1:0] cnt_clr_reg;
reg [1:0] period_en_reg;

always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        long_err_reg <= 2'b00;
        duty_err_reg <= 2'b00;
        cnt_clr_reg <= 2'b00;
        period_en_reg <= 2'b11;
    end else begin
        long_err_reg <= long_bit_i & long_bit_en;
        period_en_reg <= ~period_off;
        duty_err_reg <= start_duty_low_i & ~duty_off;
        cnt_clr_reg <= start_bit_err_i & cnt_clr_en;
    end
end

assign long_bit_error_o = long_err_reg;
assign start_period_meas_en_o = period_en_reg;
assign start_duty_error_o = duty_err_reg;
assign bit_counter_clear_o = cnt_clr_reg;

////////////////////////////////////////////////////////////////////////////////
// loop reset after error

wire loop_delay = ch2_tune_reg[`PSA_C2_LOOP_DELAY];
wire loop_delay_done;
reg loop_reset_reg;

// a fresh error during the wait restarts the 20 ms count
// an error held high keeps reloading, so the reset waits until it goes away
psa_timer #(.W(19)) u_loop (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .load_i(loop_error_i && loop_delay),
    .value_i(LOOP_DELAY_M1),
    .busy_o(),
    .done_o(loop_delay_done)
);

always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        loop_reset_reg <= 1'b0;
    end else begin
        loop_reset_reg <= (loop_error_i && !loop_delay) || loop_delay_done;
    end
end

assign loop_reset_o = loop_reset_reg;

////////////////////////////////////////////////////////////////////////////////
// channel-two sync delay

wire both_auto = ch1_sync_auto_i && ch2_sync_auto_i;
wire use_delay = both_auto && (pulse_delay != 3'b000);
wire [8:0] sync_len = SYNC_STEP_CYC * {6'd0, pulse_delay} - 9'd1;
wire sync_delay_done;
reg sync_reg;

psa_timer #(.W(9)) u_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .load_i(ch2_sync_req_i && use_delay),
    .value_i(sync_len),
    .busy_o(),
    .done_o(sync_delay_done)
);

// undelayed requests leave through the same flip-flop as the end of a delayed wait
always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        sync_reg <= 1'b0;
    end else begin
        sync_reg <= (ch2_sync_req_i && !use_delay) || sync_delay_done;
    end
end

assign ch2_sync_pulse_o = sync_reg;

endmodule // psa_adv_settings

// ==== psa_adv_monitor.sv ====
`timescale 1ns/1ps
module psa_adv_monitor (
    input wire clock_i,
    input wire arst_n_i,
    input wire [5:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [15:0] reg_wdata_i,
    input wire [1:0] long_bit_i,
    input wire [1:0] long_bit_error_o,
    input wire [1:0] start_period_meas_en_o,
    input wire [8:0] ch1_threshold_delta_o,
    input wire loop_error_i,
    input wire loop_reset_o,
    input wire ch1_sync_auto_i,
    input wire ch2_sync_auto_i,
    input wire ch2_sync_req_i,
    input wire ch2_sync_pulse_o
);
    reg [15:0] m1_reg;
    reg [15:0] m2_reg;
    // code 15 would land above the top of the range, so it is clamped
    wire [8:0] exp_delta = (m1_reg[14:11] == 4'hf) ? 9'd460 : 9'd176 + 9'd19 * m1_reg[14:11];
    wire sync_dly = ch1_sync_auto_i && ch2_sync_auto_i && m2_reg[2:0] != 3'h0;
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            m1_reg <= 16'h4000;
            m2_reg <= 16'h0000;
        end else if (reg_wr_i && reg_addr_i == 6'h2e) begin
            m1_reg <= reg_wdata_i & 16'hfbfd;
        end else if (reg_wr_i && reg_addr_i == 6'h2f) begin
            m2_reg <= reg_wdata_i & 16'h9e7f;
        end
    end
    ////////////////////////////////
    // the first edge after release still shows reset values, so checks start one edge later
    reg live_reg;
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            live_reg <= 1'b0;
        end else begin
            live_reg <= 1'b1;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i || !live_reg);
    a_long_bit_gate: assert property (1 |=> long_bit_error_o == ($past(long_bit_i) & $past({m2_reg[12], m2_reg[6]})))
        else $error("long bit gating wrong");
    a_period_meas_en: assert property (1 |=> start_period_meas_en_o == ~$past({m2_reg[11], m2_reg[5]}))
        else $error("period measure enable wrong");
    a_static_delta: assert property (1 |=> ch1_threshold_delta_o == $past(exp_delta))
        else $error("static threshold wrong");
    a_delta_range: assert property (ch1_threshold_delta_o >= 9'd176 && ch1_threshold_delta_o <= 9'd460)
        else $error("threshold out of range");
    a_loop_now: assert property (loop_error_i && !m2_reg[15] |=> loop_reset_o)
        else $error("loop reset late");
    a_loop_wait: assert property (loop_error_i && m2_reg[15] |=> !loop_reset_o [*8])
        else $error("loop reset early");
    a_sync_plain: assert property (ch2_sync_req_i && !sync_dly |=> ch2_sync_pulse_o)
        else $error("undelayed sync missing");
    a_sync_step: assert property (ch2_sync_req_i && sync_dly && m2_reg[2:0] == 3'h1 |-> ##51 ch2_sync_pulse_o)
        else $error("delayed sync misplaced");
    c_loop_late: cover property (loop_error_i && m2_reg[15]);
    c_sync_delayed: cover property (ch2_sync_req_i && sync_dly);
    c_delta_top: cover property (ch1_threshold_delta_o == 9'd460);
endmodule // psa_adv_monitor

bind psa_adv_settings psa_adv_monitor u_mon (.clock_i, .arst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .long_bit_i, .long_bit_error_o, .start_period_meas_en_o, .ch1_threshold_delta_o, .loop_error_i,
    .loop_reset_o, .ch1_sync_auto_i, .ch2_sync_auto_i, .ch2_sync_req_i, .ch2_sync_pulse_o);

// ==== psa_sensor_model.sv ====
`timescale 1ns/1ps
module psa_sensor_model (
    input wire clock_i,
    input wire arst_n_i,
    input wire level_i,
    input wire talk_i,
    input wire short_i,
    output reg data_o,
    output reg ground_short_o
);
    reg [3:0] phase_reg;
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_reg <= 4'h0;
            data_o <= 1'b0;
            ground_short_o <= 1'b0;
        end else begin
            // chatter of 8 cycles is shorter than any filter time, so it must never pass
            phase_reg <= phase_reg + 4'h1;
            data_o <= level_i ^ (talk_i & phase_reg[3]);
            ground_short_o <= short_i;
        end
    end
endmodule // psa_sensor_model

// ==== testbench.sv ====
`timescale 1ns/1ps
`define chk(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module testbench;
    reg clock_i = 0, arst_n_i = 0, reg_wr_i = 0, rate_fast_i = 1, ch1_sensor_start_i = 0;
    reg ch1_start_bits_seen_i = 1, loop_error_i = 0, ch1_sync_auto_i = 0, ch2_sync_auto_i = 0;
    reg ch2_sync_req_i = 0, sens_level = 0, sens_talk = 0, sens_short = 0;
    reg [5:0] reg_addr_i = 0;
    reg [15:0] reg_wdata_i = 0, d, v;
    reg [1:0] dec_ev = 0;
    wire [15:0] reg_rdata_o;
    wire [8:0] ch1_threshold_delta_o;
    wire [1:0] long_bit_error_o, start_period_meas_en_o, start_duty_error_o, bit_counter_clear_o;
    wire ch1_data_o, ch1_channel_off_o, ch1_blanking_o, ch1_base_hold_o, ch1_threshold_static_o;
    wire ch1_tracking_fast_o, loop_reset_o, ch2_sync_pulse_o, sens_data, sens_gs;
    integer errors = 0, checked = 0, n, w, i, len;
    always #20 clock_i = ~clock_i;
    psa_sensor_model u_sens (.clock_i, .arst_n_i, .level_i(sens_level), .talk_i(sens_talk),
        .short_i(sens_short), .data_o(sens_data), .ground_short_o(sens_gs));
    psa_adv_settings #(.BLANK_5MS_CYC(20), .BLANK_10MS_CYC(40), .LOOP_DELAY_CYC(30)) dut (.clock_i,
        .arst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .rate_fast_i, .ch1_data_i(sens_data),
        .ch1_ground_short_i(sens_gs), .ch1_sensor_start_i, .ch1_start_bits_seen_i, .ch1_data_o,
        .ch1_channel_off_o, .ch1_blanking_o, .ch1_base_hold_o, .ch1_threshold_static_o,
        .ch1_threshold_delta_o, .ch1_tracking_fast_o, .long_bit_i(dec_ev), .start_duty_low_i(dec_ev),
        .start_bit_err_i(dec_ev), .long_bit_error_o, .start_period_meas_en_o, .start_duty_error_o,
        .bit_counter_clear_o, .loop_error_i, .loop_reset_o, .ch1_sync_auto_i, .ch2_sync_auto_i,
        .ch2_sync_req_i, .ch2_sync_pulse_o);
    ////////////////////////////////
    task wr(input [5:0] a, input [15:0] x);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wr_i <= 1'b1;
        reg_wdata_i <= x;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input [5:0] a, output [15:0] x);
        @(posedge clock_i);
        reg_addr_i <= a;
        @(posedge clock_i);
        #1 x = reg_rdata_o;
    endtask
    function automatic logic probe(input integer s);
        case (s)
            0: probe = loop_reset_o;
            1: probe = ch2_sync_pulse_o;
            2: probe = ch1_data_o;
            3: probe = ch1_channel_off_o;
            default: probe = ch1_blanking_o;
        endcase
    endfunction
    // n: edges from the driving edge until the probe is seen high, w: cycles it stays high
    task kick(input integer k, input integer s, output integer n, output integer w);
        @(posedge clock_i);
        case (k)
            0: loop_error_i <= 1'b1;
            1: ch2_sync_req_i <= 1'b1;
            2: ch1_sensor_start_i <= 1'b1;
            3: sens_level <= 1'b1;
            4: sens_short <= 1'b1;
            default: sens_talk <= 1'b1;
        endcase
        @(posedge clock_i);
        loop_error_i <= 1'b0;
        ch2_sync_req_i <= 1'b0;
        ch1_sensor_start_i <= 1'b0;
        n = 1;
        w = 0;
        #1;
        while (probe(s) !== 1'b1 && n < 4000) begin @(posedge clock_i); #1; n++; end
        while (probe(s) === 1'b1 && w < 4000) begin @(posedge clock_i); #1; w++; end
    endtask
    task results;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////
    initial begin
        #(60000 * 40);
        errors++;
        results;
    end
    initial begin
        repeat (16) @(posedge clock_i);
        arst_n_i <= 1'b1;
        rd(6'h2e, d); `chk(d, 16'h4000)
        rd(6'h2f, d); `chk(d, 16'h0000)
        wr(6'h2f, 16'hffff); wr(6'h2e, 16'hffff); wr(6'h30, 16'hffff);
        rd(6'h2f, d); `chk(d, 16'h9e7f)
        rd(6'h2e, d); `chk(d, 16'hfbfd)
        rd(6'h30, d); `chk(d, 16'h0000)
        for (i = 0; i < 3; i++) begin
            v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h1e00 : 16'h0078;
            @(posedge clock_i);
            dec_ev <= 2'b11 ^ i[1:0];
            ch1_start_bits_seen_i <= (i != 1);
            wr(6'h2f, v);
            repeat (2) @(posedge clock_i);
            #1 `chk(long_bit_error_o, {v[12], v[6]} & dec_ev)
            `chk(start_period_meas_en_o, ~{v[11], v[5]})
            `chk(start_duty_error_o, ~{v[10], v[4]} & dec_ev)
            `chk(bit_counter_clear_o, {v[9], v[3]} & dec_ev)
            v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h4200 : 16'h7a05;
            wr(6'h2e, v);
            repeat (2) @(posedge clock_i);
            #1 `chk(ch1_threshold_delta_o, (v[14:11] == 4'hf) ? 9'd460 : 9'd176 + 9'd19 * v[14:11])
            `chk(ch1_threshold_static_o, v[0])
            `chk(ch1_tracking_fast_o, v[9])
            `chk(ch1_base_hold_o, ch1_start_bits_seen_i & ~v[2])
        end
        wr(6'h2f, 16'h0000);
        kick(0, 0, n, w); `chk(n * 10 + w, 11)
        wr(6'h2f, 16'h8000);
        kick(0, 0, n, w); `chk(n, 31)
        for (i = 0; i < 4; i++) begin
            @(posedge clock_i);
            ch1_sync_auto_i <= (i != 2);
            ch2_sync_auto_i <= 1'b1;
            wr(6'h2f, (i == 0) ? 16'h0001 : (i == 3) ? 16'h0000 : 16'h0003);
            kick(1, 1, n, w); `chk(n, (i == 0) ? 51 : (i == 1) ? 151 : 1)
            wr(6'h2e, {7'h00, i[1:0], 7'h00});
            kick(2, 4, n, w); `chk(w, (i == 1) ? 20 : (i == 2) ? 40 : 3200)
        end
        for (i = 0; i < 2; i++) begin
            @(posedge clock_i);
            rate_fast_i <= (i == 0);
            len = (i == 0) ? 25 : 61;
            wr(6'h2e, (i == 0) ? 16'h0000 : 16'h0078);
            kick(3, 2, n, w); `chk(n >= len && n <= len + 4, 1'b1)
            kick(4, 3, n, w); `chk(n >= len && n <= len + 4, 1'b1)
            @(posedge clock_i);
            sens_level <= 1'b0;
            sens_short <= 1'b0;
            repeat (100) @(posedge clock_i);
        end
        wr(6'h2e, 16'h8000);
        kick(4, 3, n, w); `chk(n, 4000)
        kick(5, 2, n, w); `chk(n, 4000)
        results;
    end
endmodule // testbench
